// ===== btst_pkg.sv
package btst_pkg;
	localparam logic [3:0] BTST_OP_SKIP_HI   = 4'h9;
	localparam logic       BTST_OP_SKIP_SEL  = 1'h0;
	localparam logic [3:0] BTST_OP_INV_HI    = 4'h3;
	localparam logic       BTST_OP_INV_SEL   = 1'h1;
	localparam int         BTST_OPC_MSB      = 15;
	localparam int         BTST_SEL_POS      = 11;
	localparam int         BTST_BIT_MSB      = 10;
	localparam int         BTST_BIT_LSB      = 8;
	localparam int         BTST_ADDR_MSB     = 7;
	localparam logic [15:0] BTST_NOP_WORD    = 16'h0000;
	localparam logic [1:0] BTST_PHASE_RST    = 2'h0;

	typedef enum logic [1:0] {
		BTST_Q1 = 2'b00,
		BTST_Q2 = 2'b01,
		BTST_Q3 = 2'b10,
		BTST_Q4 = 2'b11
	} btst_phase_t;
endpackage : btst_pkg

// ===== btst_phase_if.sv
`timescale 1ns/1ps
interface btst_phase_if;
	logic q1;
	logic q2;
	logic q3;
	logic q4;
	modport gen (output q1, output q2, output q3, output q4);
	modport use_ph (input q1, input q2, input q3, input q4);
endinterface : btst_phase_if

// ===== btst_phase_gen.sv
`timescale 1ns/1ps
module btst_phase_gen
	import btst_pkg::*;
(
	input  wire logic   core_clk_i,
	input  wire logic   nrst_i,
	btst_phase_if.gen   ph
);
	btst_phase_t phase;
	btst_phase_t next_phase;

	assign next_phase = btst_phase_t'(phase + 2'h1);
	assign ph.q1 = (phase == BTST_Q1);
	assign ph.q2 = (phase == BTST_Q2);
	assign ph.q3 = (phase == BTST_Q3);
	assign ph.q4 = (phase == BTST_Q4);

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			phase <= btst_phase_t'(BTST_PHASE_RST);
		else
			phase <= next_phase;
	end
endmodule : btst_phase_gen

// ===== btst_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Skip-when-set reads bit b of register f; skips next instruction if one.
// - Next instruction is fetched while the current one executes.
// - A taken skip discards prefetched word and runs a forced NOP, no write.
// - Skip-when-set is one word: one cycle, two cycles when skipping.
// - Bit invert reads location in Q2, writes inverted bit back in Q4.
module btst_core
	import btst_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [15:0] fetch_word_i,
	input  wire logic [7:0]  rf_rdata_i,
	output logic             fetch_req_o,
	output logic [15:0]      exec_word_o,
	output logic             rf_rd_o,
	output logic [7:0]       rf_addr_o,
	output logic             rf_we_o,
	output logic [7:0]       rf_wdata_o,
	output logic             status_we_o,
	output logic             skip_nop_o,
	output logic             q1_o
);
	btst_phase_if ph();

	btst_phase_gen u_phase (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.ph         (ph.gen)
	);

	logic [15:0] ir;
	logic [15:0] prefetch;
	logic        squash;
	logic [7:0]  rd_data;
	logic        skip_take;

	wire [3:0] op_hi     = ir[BTST_OPC_MSB:BTST_OPC_MSB-3];
	wire       op_sel    = ir[BTST_SEL_POS];
	wire [2:0] bit_idx   = ir[BTST_BIT_MSB:BTST_BIT_LSB];
	wire [7:0] file_addr = ir[BTST_ADDR_MSB:0];
	// Raw opcode matches; the squash gate keeps a discarded word inert.
	wire       op_skip   = (op_hi == BTST_OP_SKIP_HI)
		&& (op_sel == BTST_OP_SKIP_SEL);
	wire       op_inv    = (op_hi == BTST_OP_INV_HI)
		&& (op_sel == BTST_OP_INV_SEL);
	wire       is_skip   = op_skip && !squash;
	wire       is_inv    = op_inv && !squash;
	wire       is_bitop  = is_skip || is_inv;
	wire       tested    = rd_data[bit_idx];
	wire [7:0] bit_mask  = 8'h01 << bit_idx;
	wire [7:0] inv_data  = rd_data ^ bit_mask;
	wire [15:0] next_ir  = skip_take ? BTST_NOP_WORD : prefetch;
	wire [7:0] next_addr = next_ir[BTST_ADDR_MSB:0];

	// Prefetch of the following word runs in Q4 of every cycle.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prefetch    <= BTST_NOP_WORD;
			fetch_req_o <= 1'b0;
		end else begin
			fetch_req_o <= ph.q3;
			if (ph.q4)
				prefetch <= fetch_word_i;
		end
	end

	// The skip decision is made in Q3 from the Q2 read.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data   <= 8'h00;
			skip_take <= 1'b0;
		end else begin
			if (ph.q2)
				rd_data <= rf_rdata_i;
			if (ph.q3)
				skip_take <= is_skip && tested;
			else if (ph.q1)
				skip_take <= 1'b0;
		end
	end

	// On a skip the prefetched word is replaced by a forced NOP.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ir     <= BTST_NOP_WORD;
			squash <= 1'b1;
		end else if (ph.q4) begin
			ir     <= next_ir;
			squash <= skip_take;
		end
	end

	// Address, executing word and NOP flag load with the instruction
	// register, so each stands for the whole instruction cycle.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rf_addr_o   <= 8'h00;
			exec_word_o <= BTST_NOP_WORD;
			skip_nop_o  <= 1'b0;
		end else if (ph.q4) begin
			rf_addr_o   <= next_addr;
			exec_word_o <= next_ir;
			skip_nop_o  <= skip_take;
		end
	end

	// Register port: read strobe stands in Q2, write strobe in Q4.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rf_rd_o    <= 1'b0;
			rf_we_o    <= 1'b0;
			rf_wdata_o <= 8'h00;
		end else begin
			rf_rd_o    <= ph.q1 && is_bitop;
			rf_we_o    <= ph.q3 && is_inv;
			rf_wdata_o <= inv_data;
		end
	end

	// No flag write path exists; the strobe stays a port so that a status
	// register beside this block always sees a defined low.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_we_o <= 1'b0;
			q1_o        <= 1'b0;
		end else begin
			status_we_o <= 1'b0;
			q1_o        <= ph.q4;
		end
	end

	// Each strobe must land in its own phase slot of the cycle.
	chk_write_in_q4: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) rf_we_o |-> $past(ph.q3))
		else $error("write outside Q4");

	chk_no_write_squash: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) squash |-> !rf_we_o)
		else $error("write during forced NOP");

	chk_skip_nop_load: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) (ph.q4 && skip_take) |=> (ir == BTST_NOP_WORD))
		else $error("skip did not force NOP");

	chk_skip_decide: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) (ph.q3 && is_skip && tested) |=> skip_take)
		else $error("skip not taken");

	chk_no_skip_clear: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) (ph.q3 && !(is_skip && tested)) |=> !skip_take)
		else $error("spurious skip");

	chk_prefetch_q4: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) (ph.q4 && !skip_take) |=> (ir == $past(prefetch)))
		else $error("prefetch not executed");

	chk_one_nop_cycle: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) (ph.q4 && skip_take) |=> squash ##4 !squash)
		else $error("skip lasted wrong length");

	chk_inv_value: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) rf_we_o |->
		(rf_wdata_o ^ $past(rd_data, 1)) == (8'h01 << $past(bit_idx)))
		else $error("invert data wrong");

	chk_status_quiet: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) !status_we_o)
		else $error("status flags written");

	chk_read_in_q2: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) rf_rd_o |-> $past(ph.q1))
		else $error("read outside Q2");

	chk_no_read_squash: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) squash |-> !rf_rd_o)
		else $error("read during forced NOP");

	chk_we_single: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) rf_we_o |=> !rf_we_o)
		else $error("write strobe too long");

	chk_inv_one_cycle: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) (ph.q1 && is_inv) |-> ##3 rf_we_o)
		else $error("invert not done in one cycle");

	chk_write_addr: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) rf_we_o |-> (rf_addr_o == file_addr))
		else $error("write to wrong location");

	chk_read_addr: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) rf_rd_o |-> (rf_addr_o == file_addr))
		else $error("read from wrong location");

	chk_fetch_in_q4: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) fetch_req_o |-> ph.q4)
		else $error("fetch outside Q4");

	chk_fetch_each: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) ph.q4 |-> fetch_req_o)
		else $error("fetch missing in Q4");

	chk_exec_follows: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) exec_word_o == ir)
		else $error("executing word out of step");

	chk_nop_length: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i)
		(ph.q4 && skip_take) |=> skip_nop_o[*4] ##1 !skip_nop_o)
		else $error("forced NOP not one cycle");

	chk_nop_cleared: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i) (ph.q4 && !skip_take) |=> !skip_nop_o)
		else $error("NOP flag without skip");

	chk_phase_ring: assert property (@(posedge core_clk_i)
		disable iff (!nrst_i)
		ph.q1 |=> ph.q2 ##1 ph.q3 ##1 ph.q4 ##1 ph.q1)
		else $error("phase order broken");

	cov_skip: cover property (@(posedge core_clk_i) ph.q4 && skip_take);
	cov_noskip: cover property (@(posedge core_clk_i)
		ph.q3 && is_skip && !tested);
	cov_invert: cover property (@(posedge core_clk_i) rf_we_o);
	cov_inv_burst: cover property (@(posedge core_clk_i)
		rf_we_o ##4 rf_we_o);
	cov_nop_cycle: cover property (@(posedge core_clk_i)
		skip_nop_o[*4]);
endmodule : btst_core

// ===== btst_rf_model.sv
`timescale 1ns/1ps
module btst_rf_model (
	input  wire logic       core_clk_i,
	input  wire logic [7:0] rf_addr_i,
	input  wire logic       rf_rd_i,
	input  wire logic       rf_we_i,
	input  wire logic [7:0] rf_wdata_i,
	output logic [7:0]      rf_rdata_o
);
	logic [7:0] mem [256];
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i);
	end
	// Unselected reads return inverted data so a stale sample shows up.
	assign rf_rdata_o = rf_rd_i ? mem[rf_addr_i] : ~mem[rf_addr_i];
	always @(posedge core_clk_i) begin
		if (rf_we_i === 1'b1) mem[rf_addr_i] <= rf_wdata_i;
	end
endmodule : btst_rf_model

// ===== bit_test_skip_and_toggle_tb.sv
`timescale 1ns/1ps
module bit_test_skip_and_toggle_tb;
	logic        clk = 0, nrst = 0;
	logic [15:0] fw = 16'h0000, ew;
	logic [7:0]  rd, ad, wd;
	logic        fr, rr, we, swe, sk, q1, sk_d = 0, fr_d = 0;
	int          failures = 0, n_checks = 0, n_we = 0, n_sk = 0, cyc = 0;
	int          n_skc = 0, n_ex = 0;
	always #2.5 clk = ~clk;
	btst_core dut_u (.core_clk_i(clk), .nrst_i(nrst), .fetch_word_i(fw),
		.rf_rdata_i(rd), .fetch_req_o(fr), .exec_word_o(ew), .rf_rd_o(rr),
		.rf_addr_o(ad), .rf_we_o(we), .rf_wdata_o(wd), .status_we_o(swe),
		.skip_nop_o(sk), .q1_o(q1));
	btst_rf_model rf_u (.core_clk_i(clk), .rf_addr_i(ad), .rf_rd_i(rr),
		.rf_we_i(we), .rf_wdata_i(wd), .rf_rdata_o(rd));
	always @(negedge clk) begin
		sk_d <= sk;
		fr_d <= fr;
		if (we === 1'b1) n_we++;
		if (sk === 1'b1 && sk_d !== 1'b1) n_sk++;
		if (sk === 1'b1) n_skc++;
		if (q1 === 1'b1 && ew === 16'h3830) n_ex++;
		if (q1 !== fr_d) chk({7'h00, q1}, {7'h00, fr_d});
		if (swe !== 1'b0) chk(8'(swe), 8'h00);
		cyc++;
		if (cyc == 3000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// The word is taken at the following fetch, so words are fed one ahead.
	task automatic feed(input logic [15:0] w);
		do @(negedge clk); while (fr !== 1'b1);
		@(posedge clk) fw <= w;
	endtask : feed
	task automatic test_invert();
		for (int b = 0; b < 8; b++) feed(16'h3812 | 16'(b << 8));
		repeat (4) feed(16'h0000);
		chk(rf_u.mem[8'h12], 8'hED);
		chk(8'(n_we), 8'h08);
	endtask : test_invert
	task automatic test_skip(input logic [2:0] b, input logic [7:0] exp);
		int we0, sk0, skc0, ex0;
		we0 = n_we;
		sk0 = n_sk;
		skc0 = n_skc;
		ex0 = n_ex;
		feed(16'h9021 | {5'h00, b, 8'h00});
		feed(16'h3830);
		repeat (4) feed(16'h0000);
		chk(rf_u.mem[8'h30], exp);
		chk(8'(n_sk - sk0), {7'h00, exp == 8'h30});
		chk(8'(n_we - we0), {7'h00, exp != 8'h30});
		chk(8'(n_ex - ex0), {7'h00, exp != 8'h30});
		chk(8'(n_skc - skc0), (exp == 8'h30) ? 8'h04 : 8'h00);
	endtask : test_skip
	task automatic summarize();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		test_invert();
		test_skip(3'h0, 8'h30);
		test_skip(3'h1, 8'h31);
		summarize();
	end
endmodule : bit_test_skip_and_toggle_tb
